// file: src/fep_pkg.sv
// flash erase and protection: shared constants, enumerations and carriers
// assumes a single 250 MHz clock domain and a byte-addressed 128 KB array
package fep_pkg;

  // ----------------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------------
  localparam int FLASH_BYTES = 131072;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int WORD_LSB = 2;
  localparam int WORD_AW = ADDR_W - WORD_LSB;
  localparam int FLASH_WORDS = FLASH_BYTES / 4;
  localparam int ERASE_BYTES = 1024;
  localparam int UNIT_LSB = 10;
  localparam int UNIT_W = ADDR_W - UNIT_LSB;
  localparam int ERASE_WORDS = 256;
  localparam int ERASE_CNT_W = 8;
  localparam int PROT_BYTES = 2048;
  localparam int REGION_LSB = 11;
  localparam int REGION_W = ADDR_W - REGION_LSB;
  localparam int NUM_REGIONS = 64;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------------
  // read paths, indexed into the read request and answer arrays
  // ----------------------------------------------------------------------
  localparam int NUM_RD = 3;
  localparam int PORT_FETCH = 0;
  localparam int PORT_DATA = 1;
  localparam int PORT_DEBUG = 2;

  // ----------------------------------------------------------------------
  // commands and protection modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {FEP_OP_PROGRAM, FEP_OP_ERASE, FEP_OP_PROTECT} fep_op_e;
  typedef enum logic [1:0] {FEP_PROT_OPEN, FEP_PROT_RO, FEP_PROT_XO} fep_prot_e;

  typedef struct packed {
    logic valid;
    fep_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    fep_prot_e prot;
  } fep_cmd_s;

  typedef struct packed {
    logic pulse;
    logic refused;
  } fep_done_s;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
  } fep_rd_req_s;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [DATA_W-1:0] data;
  } fep_rd_rsp_s;

endpackage : fep_pkg

// file: src/fep_array.sv
// flash cell array: one write port, several combinational read ports
// assumes the controller serialises writes; contents are unknown until erased
`timescale 1ns/1ns
module fep_array #(
  parameter int WORDS = fep_pkg::FLASH_WORDS,
  parameter int AW = fep_pkg::WORD_AW,
  parameter int DW = fep_pkg::DATA_W,
  parameter int NRD = fep_pkg::NUM_RD
) (
  // clock
  input logic ref_clk_i,
  // write port
  input logic wr_en_i,
  input logic wr_erase_i,
  input logic [AW-1:0] wr_addr_i,
  input logic [DW-1:0] wr_data_i,
  // read ports
  input logic [NRD-1:0][AW-1:0] rd_addr_i,
  output logic [NRD-1:0][DW-1:0] rd_data_o
);
  import fep_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [DW-1:0] mem [WORDS];

  generate
    if (WORDS > 2 ** AW) begin : g_bad_size
      $error("fep_array: WORDS exceeds address range");
    end
  endgenerate

  // programming can only clear bits, as a real cell does; erase sets them all
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_erase_i ? ERASED_WORD[DW-1:0] : (mem[wr_addr_i] & wr_data_i);
    end
  end

  // ----------------------------------------------------------------------
  // read ports
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NRD; g++) begin : g_rd
      assign rd_data_o[g] = mem[rd_addr_i[g]];
    end
  endgenerate

endmodule : fep_array

// file: src/fep_ctrl.sv
// flash controller: erase sequencing, programming and region protection
// assumes requesters hold nothing: reads answer one cycle after the request
`timescale 1ns/1ns
module fep_ctrl #(
  parameter int FLASH_BYTES = fep_pkg::FLASH_BYTES
) (
  // clock and reset
  input logic ref_clk_i,
  input logic reset_i,
  // command port
  input fep_pkg::fep_cmd_s cmd_i,
  output logic cmd_ready_o,
  output fep_pkg::fep_done_s done_o,
  output logic busy_o,
  // read paths: fetch, data, debug
  input fep_pkg::fep_rd_req_s [fep_pkg::NUM_RD-1:0] rd_req_i,
  output fep_pkg::fep_rd_rsp_s [fep_pkg::NUM_RD-1:0] rd_rsp_o
);
  import fep_pkg::*;

  typedef enum logic {ST_IDLE, ST_ERASE} fep_state_e;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (FLASH_BYTES != 2 ** ADDR_W || FLASH_BYTES % PROT_BYTES != 0) begin : g_bad_size
      $error("fep_ctrl: FLASH_BYTES must fill the address width in whole regions");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------------------
  function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    region_of = a[ADDR_W-1:REGION_LSB];
  endfunction : region_of

  function automatic logic [WORD_AW-1:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = a[ADDR_W-1:WORD_LSB];
  endfunction : word_of

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  fep_state_e state, next_state;
  logic [UNIT_W-1:0] unit, next_unit;
  logic [ERASE_CNT_W-1:0] cnt, next_cnt;
  fep_prot_e prot [NUM_REGIONS];
  fep_prot_e next_prot [NUM_REGIONS];
  fep_done_s next_done;
  logic wr_en;
  logic wr_erase;
  logic [WORD_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [NUM_RD-1:0][WORD_AW-1:0] rd_addr;
  logic [NUM_RD-1:0][DATA_W-1:0] rd_data;
  logic [REGION_W-1:0] cmd_region;
  logic locked;

  assign cmd_region = region_of(cmd_i.addr);
  assign locked = prot[cmd_region] != FEP_PROT_OPEN;
  // commands wait while an erase walks its unit
  assign cmd_ready_o = state == ST_IDLE;
  assign busy_o = state == ST_ERASE;

  // command sequencing; protection is checked once, at acceptance
  always_comb begin
    next_state = state;
    next_unit = unit;
    next_cnt = cnt;
    next_prot = prot;
    next_done = '0;
    wr_en = 1'b0;
    wr_erase = 1'b0;
    wr_addr = word_of(cmd_i.addr);
    wr_data = cmd_i.data;
    case (state)
      ST_IDLE: begin
        if (cmd_i.valid) begin
          case (cmd_i.op)
            FEP_OP_PROGRAM: begin
              next_done.pulse = 1'b1;
              next_done.refused = locked;
              wr_en = !locked;
            end
            FEP_OP_ERASE: begin
              if (locked) begin
                next_done.pulse = 1'b1;
                next_done.refused = 1'b1;
              end else begin
                next_state = ST_ERASE;
                next_unit = cmd_i.addr[ADDR_W-1:UNIT_LSB];
                next_cnt = '0;
              end
            end
            FEP_OP_PROTECT: begin
              // protection only tightens; a locked region keeps its mode until reset
              next_done.pulse = 1'b1;
              if (locked && cmd_i.prot != prot[cmd_region]) begin
                next_done.refused = 1'b1;
              end else begin
                next_prot[cmd_region] = cmd_i.prot;
              end
            end
            default: begin
              next_done.pulse = 1'b1;
              next_done.refused = 1'b1;
            end
          endcase
        end
      end
      ST_ERASE: begin
        // one word per cycle keeps the write port simple at the cost of 256 cycles
        wr_en = 1'b1;
        wr_erase = 1'b1;
        wr_addr = {unit, cnt};
        next_cnt = cnt + 1'b1;
        if (cnt == ERASE_CNT_W'(ERASE_WORDS - 1)) begin
          next_state = ST_IDLE;
          next_done.pulse = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // command state registers; every region starts open
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      unit <= '0;
      cnt <= '0;
      done_o <= '0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
        prot[r] <= FEP_PROT_OPEN;
      end
    end else begin
      state <= next_state;
      unit <= next_unit;
      cnt <= next_cnt;
      done_o <= next_done;
      prot <= next_prot;
    end
  end

  // ----------------------------------------------------------------------
  // cell array
  // ----------------------------------------------------------------------
  fep_array #(
    .WORDS(FLASH_WORDS),
    .AW(WORD_AW),
    .DW(DATA_W),
    .NRD(NUM_RD)
  ) u_array (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(wr_en),
    .wr_erase_i(wr_erase),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  // ----------------------------------------------------------------------
  // read paths
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_RD; g++) begin : g_rd
      fep_rd_rsp_s rsp, next_rsp;
      logic deny;

      assign rd_addr[g] = word_of(rd_req_i[g].addr);
      // only the fetch path may see execute-only code
      assign deny = (g != PORT_FETCH) &&
        prot[region_of(rd_req_i[g].addr)] == FEP_PROT_XO;

      // denied answers carry zeros so nothing leaks through the data lanes
      always_comb begin
        next_rsp = '0;
        next_rsp.valid = rd_req_i[g].req;
        next_rsp.denied = rd_req_i[g].req && deny;
        if (rd_req_i[g].req && !deny) begin
          next_rsp.data = rd_data[g];
        end
      end

      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          rsp <= '0;
        end else begin
          rsp <= next_rsp;
        end
      end

      assign rd_rsp_o[g] = rsp;

      chk_read_answer: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rd_req_i[g].req |=> rd_rsp_o[g].valid)
        else $error("read request got no answer next cycle");

      chk_xo_read_deny: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rd_req_i[g].req && prot[region_of(rd_req_i[g].addr)] == FEP_PROT_XO
        |=> rd_rsp_o[g].denied == (g != PORT_FETCH))
        else $error("execute-only read handled on wrong path");

      chk_deny_no_data: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rd_rsp_o[g].denied |-> rd_rsp_o[g].data == '0 && rd_rsp_o[g].valid)
        else $error("denied read returned data");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks on the command side
  // ----------------------------------------------------------------------
  chk_erase_length: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_IDLE && cmd_i.valid && cmd_i.op == FEP_OP_ERASE && !locked
    |=> busy_o ##255 busy_o ##1 (!busy_o && done_o.pulse && !done_o.refused))
    else $error("erase did not take exactly one unit of words");

  chk_erase_ones: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    busy_o |-> wr_en && wr_erase && wr_addr[WORD_AW-1:ERASE_CNT_W] == unit)
    else $error("erase wrote outside its unit or without all ones");

  chk_protect_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_IDLE && cmd_i.valid && cmd_i.op == FEP_OP_PROTECT && !locked
    |=> prot[$past(cmd_region)] == $past(cmd_i.prot))
    else $error("protection mode not stored for open region");

  chk_locked_prog: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_IDLE && cmd_i.valid && cmd_i.op == FEP_OP_PROGRAM && locked
    |-> !wr_en ##1 (done_o.pulse && done_o.refused))
    else $error("program reached a protected region");

  chk_locked_erase: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_IDLE && cmd_i.valid && cmd_i.op == FEP_OP_ERASE && locked
    |=> !busy_o && done_o.pulse && done_o.refused)
    else $error("erase started on a protected region");

  chk_no_write_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_en && !busy_o |-> prot[region_of(cmd_i.addr)] == FEP_PROT_OPEN)
    else $error("array written under protection");

endmodule : fep_ctrl

// file: tb/fep_host_model.sv
// host-side model: command issuer plus fetch, data and debug read requesters
// assumes one bench thread calls the tasks, and only while the controller is idle
`timescale 1ns/1ns
module fep_host_model (
  // clock
  input wire logic ref_clk_i,
  // command side
  output fep_pkg::fep_cmd_s cmd_o,
  input wire logic cmd_ready_i,
  input fep_pkg::fep_done_s done_i,
  input wire logic busy_i,
  // read paths
  output fep_pkg::fep_rd_req_s [fep_pkg::NUM_RD-1:0] rd_req_o,
  input fep_pkg::fep_rd_rsp_s [fep_pkg::NUM_RD-1:0] rd_rsp_i
);
  import fep_pkg::*;

  // ----------------------------------------------------------------------
  // requesters
  // ----------------------------------------------------------------------
  // idle requests carry inverted leftovers so nothing passes on stale values
  initial begin
    cmd_o = '0;
    rd_req_o = '0;
  end

  // one command, driven after the first edge and taken at the next; waits for done, counting cycles in which
  // busy is up and ready is down, so a ready stuck high shows as a short count
  task automatic send_cmd(input fep_op_e op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input fep_prot_e p, output logic refused,
      output int busy_n);
    fep_cmd_s c;
    busy_n = 0;
    refused = 1'bx;
    @(posedge ref_clk_i);
    cmd_o <= '{1'b1, op, a, d, p};
    @(posedge ref_clk_i);
    c = ~cmd_o;
    c.valid = 1'b0;
    cmd_o <= c;
    for (int n = 0; n < 300; n++) begin
      #1;
      if (busy_i === 1'b1 && cmd_ready_i === 1'b0) busy_n++;
      if (done_i.pulse === 1'b1) begin
        refused = done_i.refused;
        break;
      end
      @(posedge ref_clk_i);
    end
  endtask : send_cmd

  // one read on path g; the answer stands in the cycle after the request
  task automatic do_read(input int g, input logic [ADDR_W-1:0] a,
      output fep_rd_rsp_s rsp);
    fep_rd_req_s [NUM_RD-1:0] r;
    @(posedge ref_clk_i);
    r = rd_req_o;
    r[g] = '{1'b1, a};
    rd_req_o <= r;
    @(posedge ref_clk_i);
    r[g] = '{1'b0, ~a};
    rd_req_o <= r;
    #1 rsp = rd_rsp_i[g];
  endtask : do_read
endmodule : fep_host_model

// file: tb/tb_top.sv
// self-checking bench for the flash erase and protection controller
// assumes the host model drives the command and read request inputs; the bench drives clock and reset
`timescale 1ns/1ns
module tb_top;
  import fep_pkg::*;

  // ----------------------------------------------------------------------
  // signals and rows
  // ----------------------------------------------------------------------
  typedef struct {int path; fep_op_e op; logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data; fep_prot_e prot; int flag; logic [DATA_W-1:0] exp;} fep_row_s;
  localparam fep_op_e prg = FEP_OP_PROGRAM;
  localparam fep_op_e ers = FEP_OP_ERASE;
  localparam fep_op_e prt = FEP_OP_PROTECT;
  localparam fep_prot_e opn = FEP_PROT_OPEN;
  logic ref_clk_i, reset_i, cmd_ready, busy, flag;
  fep_cmd_s cmd;
  fep_done_s done;
  fep_rd_req_s [NUM_RD-1:0] rd_req;
  fep_rd_rsp_s [NUM_RD-1:0] rd_rsp;
  fep_rd_rsp_s rsp;
  int bad_count = 0, cmp_count = 0, nbusy;
  // path -1 marks a command row; flag is refused for commands, denied for reads
  fep_row_s rows [24] = '{
    '{-1,ers,17'h0_0000,32'h0,opn,0,32'h0}, '{0,ers,17'h0_0000,32'h0,opn,0,32'hFFFF_FFFF},
    '{1,ers,17'h0_03FC,32'h0,opn,0,32'hFFFF_FFFF}, '{-1,ers,17'h0_0400,32'h0,opn,0,32'h0},
    '{-1,prg,17'h0_0400,32'h1234_5678,opn,0,32'h0}, '{1,ers,17'h0_0400,32'h0,opn,0,32'h1234_5678},
    '{-1,prg,17'h0_0000,32'hA5A5_A5A5,opn,0,32'h0}, '{-1,ers,17'h0_07FC,32'h0,opn,0,32'h0},
    '{2,ers,17'h0_0000,32'h0,opn,0,32'hA5A5_A5A5}, '{1,ers,17'h0_0400,32'h0,opn,0,32'hFFFF_FFFF},
    '{-1,ers,17'h1_FC00,32'h0,opn,0,32'h0}, '{1,ers,17'h1_FFFC,32'h0,opn,0,32'hFFFF_FFFF},
    '{-1,prt,17'h0_0000,32'h0,FEP_PROT_RO,0,32'h0}, '{-1,prg,17'h0_0000,32'h0,opn,1,32'h0},
    '{-1,ers,17'h0_0400,32'h0,opn,1,32'h0}, '{2,ers,17'h0_0000,32'h0,opn,0,32'hA5A5_A5A5},
    '{-1,prt,17'h1_F800,32'h0,FEP_PROT_XO,0,32'h0}, '{-1,ers,17'h1_FC00,32'h0,opn,1,32'h0},
    '{-1,prg,17'h1_F800,32'h0,opn,1,32'h0}, '{0,ers,17'h1_FFFC,32'h0,opn,0,32'hFFFF_FFFF},
    '{1,ers,17'h1_FFFC,32'h0,opn,1,32'h0}, '{2,ers,17'h1_F800,32'h0,opn,1,32'h0},
    '{-1,prt,17'h0_07FC,32'h0,FEP_PROT_XO,1,32'h0}, '{-1,ers,17'h0_0800,32'h0,opn,0,32'h0}};

  // clock: 4 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  fep_ctrl DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_i(cmd),
    .cmd_ready_o(cmd_ready), .done_o(done), .busy_o(busy), .rd_req_i(rd_req),
    .rd_rsp_o(rd_rsp));
  fep_host_model host (.ref_clk_i(ref_clk_i), .cmd_o(cmd), .cmd_ready_i(cmd_ready),
    .done_i(done), .busy_i(busy), .rd_req_o(rd_req), .rd_rsp_i(rd_rsp));

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // watchdog: the whole run needs about 1350 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    stop_test();
  end

  // reset held three cycles and released on an edge; busy, done and read answers must stay quiet meanwhile
  task automatic do_reset();
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 check("quiet outputs", 32'(|{busy, done, rd_rsp}), 32'h0);
    check("ready in reset", 32'(cmd_ready), 32'h1);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].path < 0) begin
        host.send_cmd(rows[i].op, rows[i].addr, rows[i].data, rows[i].prot, flag, nbusy);
        check("refused", 32'(flag), rows[i].flag);
        check("busy cycles", nbusy, (rows[i].op == ers && rows[i].flag == 0) ? 256 : 0);
      end else begin
        host.do_read(rows[i].path, rows[i].addr, rsp);
        check("read valid", 32'(rsp.valid), 32'h1);
        check("denied", 32'(rsp.denied), rows[i].flag);
        check("read data", rsp.data, rows[i].exp);
      end
    end
    // a second reset opens every region again; the array keeps its contents
    do_reset();
    host.send_cmd(prg, 17'h0_0000, 32'h0, opn, flag, nbusy);
    check("refused after reset", 32'(flag), 32'h0);
    host.do_read(1, 17'h1_FFFC, rsp);
    check("denied after reset", 32'(rsp.denied), 32'h0);
    check("data after reset", rsp.data, 32'hFFFF_FFFF);
    host.do_read(2, 17'h0_0000, rsp);
    check("program after reset", rsp.data, 32'h0);
    stop_test();
  end
endmodule : tb_top
